//--- core/ogr_pkg.sv
// Purpose: shared constants and types of the eeprom, retry and swap register bank
// Assumes: 32-bit register word, byte offsets on the register port
// Notes: all offsets, the retry and swap reset values, and the field positions except swap select and small rom offset live here
package ogr_pkg;
    // register offsets
    localparam logic [7:0] OFF_ROM = 8'h04;
    localparam logic [7:0] OFF_RETRY = 8'h08;
    localparam logic [7:0] OFF_SWAP_DATA = 8'h0C;
    localparam logic [7:0] OFF_SWAP_CTRL = 8'h14;
    // eeprom byte access fields
    localparam int ROM_CLR_BIT = 31;
    localparam int ROM_GO_BIT = 25;
    localparam int ROM_DATA_LSB = 16;
    // retry limit fields, unit i sits at i*4
    localparam int RTY_W = 4;
    localparam int RTY_UNITS = 3;
    localparam logic [11:0] RTY_RESET = 12'h000;
    // swap control fields
    localparam int SWAP_DONE_BIT = 31;
    localparam logic SWAP_DONE_RESET = 1'b1;
    localparam logic [1:0] SWAP_SEL_RESET = 2'h0;
    localparam logic [31:0] SWAP_DATA_RESET = 32'h0000_0000;
    // small rom discovery
    localparam logic [7:0] MINI_ROM_BYTE = 8'h06;
    localparam int MINI_ROM_FLAG_BIT = 5;
    localparam logic [7:0] MINI_ROM_OFFSET = 8'h20;
    // cycles the presence sync needs before it is trusted
    localparam logic [1:0] SYNC_WAIT = 2'h3;
    typedef enum logic [1:0] {OGR_IDLE, OGR_READ, OGR_RELEASE} ogr_ee_state_t;
endpackage

//--- core/ogr_regs.sv
// Purpose: eeprom byte access, async retry limits and swap data registers
// Assumes: register port and unit strobes on clk_sys; eeprom pins asynchronous
// Notes: eeprom link is a four-phase req/ack byte handshake
`timescale 1ns/1ps
module ogr_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // serial eeprom byte link
    input wire logic ee_detect,
    input wire logic ee_ack,
    input wire logic [7:0] ee_data,
    output logic ee_req,
    output logic [7:0] ee_addr,
    output logic eeprom_present_flag,
    output logic boot_done,
    // transmit units: 0 request, 1 reply, 2 physical reply
    input wire logic [2:0] unit_start,
    input wire logic [2:0] unit_bad_ack,
    output logic [2:0] unit_retry,
    output logic [2:0] unit_give_up,
    // compare-swap engine
    input wire logic swap_complete,
    input wire logic swap_value_load,
    input wire logic [31:0] swap_value_in,
    output logic [1:0] swap_target_select
);
    typedef struct packed {
        ogr_pkg::ogr_ee_state_t st;
        logic booting;
        logic boot_pend;
        logic [1:0] boot_wait;
        logic rom_pointer_clear;
        logic byte_fetch_go;
        logic [7:0] fetched_byte;
        logic [7:0] ptr;
        logic small_rom;
        logic req;
        logic [7:0] req_addr;
        logic boot_done;
        logic [11:0] rty;
        logic [31:0] swap_data;
        logic swap_finished;
        logic [1:0] swap_sel;
        logic [31:0] rdata;
        logic rvalid;
        logic present;
        logic ack_s1;
        logic ack_s2;
        logic [7:0] data_s1;
        logic [7:0] data_s2;
        logic pres_s1;
        logic pres_s2;
    } ogr_state_t;

    ogr_state_t s_q, s_d;
    logic [31:0] rd_word;

    // read mux, unmapped offsets answer zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (reg_addr)
            ogr_pkg::OFF_ROM: begin
                rd_word[ogr_pkg::ROM_CLR_BIT] = s_q.rom_pointer_clear;
                rd_word[ogr_pkg::ROM_GO_BIT] = s_q.byte_fetch_go;
                rd_word[ogr_pkg::ROM_DATA_LSB +: 8] = s_q.fetched_byte;
                rd_word[7:0] = s_q.small_rom ? ogr_pkg::MINI_ROM_OFFSET : 8'h00;
                // remaining bits stay zero
            end
            ogr_pkg::OFF_RETRY: begin
                rd_word[11:0] = s_q.rty; // upper bound fields stay zero
            end
            ogr_pkg::OFF_SWAP_DATA: begin
                rd_word = s_q.swap_data;
            end
            ogr_pkg::OFF_SWAP_CTRL: begin
                rd_word[ogr_pkg::SWAP_DONE_BIT] = s_q.swap_finished;
                rd_word[1:0] = s_q.swap_sel;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // next state of the whole bank
    always_comb begin
        s_d = s_q;
        s_d.rvalid = reg_rd;
        if (reg_rd) begin
            s_d.rdata = rd_word;
        end
        // two-flop synchronisers for the eeprom ack and data pins, three flops for detect
        s_d.ack_s1 = ee_ack;
        s_d.ack_s2 = s_q.ack_s1;
        s_d.data_s1 = ee_data;
        s_d.data_s2 = s_q.data_s1;
        s_d.pres_s1 = ee_detect;
        s_d.pres_s2 = s_q.pres_s1;
        s_d.present = s_q.pres_s2;
        // register writes; set-only bits never clear from software
        if (reg_wr) begin
            case (reg_addr)
                ogr_pkg::OFF_ROM: begin
                    if (reg_wdata[ogr_pkg::ROM_CLR_BIT]) begin
                        s_d.rom_pointer_clear = 1'b1;
                    end
                    if (reg_wdata[ogr_pkg::ROM_GO_BIT]) begin
                        s_d.byte_fetch_go = 1'b1;
                    end
                end
                ogr_pkg::OFF_RETRY: begin
                    s_d.rty = reg_wdata[11:0];
                end
                ogr_pkg::OFF_SWAP_CTRL: begin
                    s_d.swap_finished = 1'b0;
                    s_d.swap_sel = reg_wdata[1:0];
                end
                default: begin
                end
            endcase
        end
        // completion is applied after the write so a same-cycle set wins
        if (swap_complete) begin
            s_d.swap_finished = 1'b1;
        end
        if (swap_value_load) begin
            s_d.swap_data = swap_value_in;
        end
        // eeprom sequencer
        case (s_q.st)
            ogr_pkg::OGR_IDLE: begin
                if (s_q.boot_pend) begin
                    // wait out the presence sync before trusting it
                    if (s_q.boot_wait != ogr_pkg::SYNC_WAIT) begin
                        s_d.boot_wait = s_q.boot_wait + 2'h1;
                    end else begin
                        s_d.boot_pend = 1'b0;
                        if (s_q.present) begin
                            s_d.booting = 1'b1;
                            s_d.req = 1'b1;
                            s_d.req_addr = ogr_pkg::MINI_ROM_BYTE;
                            s_d.st = ogr_pkg::OGR_READ;
                        end else begin
                            s_d.boot_done = 1'b1;
                        end
                    end
                end else if (s_q.rom_pointer_clear) begin
                    // clear first: fetched byte untouched
                    s_d.ptr = 8'h00;
                    s_d.rom_pointer_clear = reg_wr && reg_addr == ogr_pkg::OFF_ROM
                        && reg_wdata[ogr_pkg::ROM_CLR_BIT]; // same-cycle set wins
                end else if (s_q.byte_fetch_go) begin
                    s_d.req = 1'b1;
                    s_d.req_addr = s_q.ptr;
                    s_d.st = ogr_pkg::OGR_READ;
                end
            end
            ogr_pkg::OGR_READ: begin
                if (s_q.ack_s2) begin
                    s_d.req = 1'b0;
                    s_d.st = ogr_pkg::OGR_RELEASE;
                    if (s_q.booting) begin
                        s_d.small_rom = s_q.data_s2[ogr_pkg::MINI_ROM_FLAG_BIT];
                    end else begin
                        s_d.fetched_byte = s_q.data_s2;
                        s_d.ptr = s_q.ptr + 8'h01;
                    end
                end
            end
            ogr_pkg::OGR_RELEASE: begin
                if (!s_q.ack_s2) begin
                    s_d.st = ogr_pkg::OGR_IDLE;
                    if (s_q.booting) begin
                        s_d.booting = 1'b0;
                        s_d.boot_done = 1'b1;
                    end else begin
                        s_d.byte_fetch_go = reg_wr && reg_addr == ogr_pkg::OFF_ROM
                            && reg_wdata[ogr_pkg::ROM_GO_BIT]; // same-cycle set wins
                    end
                end
            end
            default: begin
                s_d.st = ogr_pkg::OGR_IDLE;
                s_d.req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= ogr_pkg::OGR_IDLE;
            s_q.boot_pend <= 1'b1;
            s_q.rty <= ogr_pkg::RTY_RESET;
            s_q.swap_data <= ogr_pkg::SWAP_DATA_RESET;
            s_q.swap_finished <= ogr_pkg::SWAP_DONE_RESET;
            s_q.swap_sel <= ogr_pkg::SWAP_SEL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // retry counters, one per transmit unit
    ogr_retry_if #(.W(ogr_pkg::RTY_W)) rif [ogr_pkg::RTY_UNITS] ();
    genvar gi;
    generate
        for (gi = 0; gi < ogr_pkg::RTY_UNITS; gi++) begin : g_unit
            assign rif[gi].limit = s_q.rty[gi*ogr_pkg::RTY_W +: ogr_pkg::RTY_W];
            assign rif[gi].start = unit_start[gi];
            assign rif[gi].bad_ack = unit_bad_ack[gi];
            assign unit_retry[gi] = rif[gi].retry;
            assign unit_give_up[gi] = rif[gi].give_up;
            ogr_retry_unit #(.W(ogr_pkg::RTY_W)) u_rty (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .rif(rif[gi])
            );
        end
    endgenerate

    // outputs straight from flops
    assign reg_rdata = s_q.rdata;
    assign reg_rvalid = s_q.rvalid;
    assign ee_req = s_q.req;
    assign ee_addr = s_q.req_addr;
    assign eeprom_present_flag = s_q.present;
    assign boot_done = s_q.boot_done;
    assign swap_target_select = s_q.swap_sel;

    a_clear_drops_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_q.rom_pointer_clear && s_q.st == ogr_pkg::OGR_IDLE && !s_q.boot_pend && !reg_wr
        |=> !s_q.rom_pointer_clear && s_q.ptr == 8'h00)
        else $error("pointer clear not completed");
    a_clear_keeps_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_q.st == ogr_pkg::OGR_IDLE |=> $stable(s_q.fetched_byte))
        else $error("fetched byte changed without a read");
    a_fetch_done_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_q.st == ogr_pkg::OGR_RELEASE && !s_q.ack_s2 && !s_q.booting && !reg_wr
        |=> !s_q.byte_fetch_go && s_q.st == ogr_pkg::OGR_IDLE)
        else $error("fetch bit not cleared");
    a_fetch_advances: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_q.st == ogr_pkg::OGR_READ && s_q.ack_s2 && !s_q.booting
        |=> s_q.ptr == $past(s_q.ptr) + 8'h01 && s_q.fetched_byte == $past(s_q.data_s2))
        else $error("fetch did not advance pointer");
    a_rom_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == ogr_pkg::OFF_ROM
        |=> reg_rvalid && reg_rdata[30:26] == 5'h00 && !reg_rdata[24]
            && reg_rdata[15:8] == 8'h00)
        else $error("eeprom reserved bits not zero");
    a_retry_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == ogr_pkg::OFF_RETRY |=> reg_rdata[31:12] == 20'h00000)
        else $error("retry upper fields not zero");
    a_swap_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        swap_complete |=> s_q.swap_finished)
        else $error("swap finished flag lost");
    a_swap_write_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == ogr_pkg::OFF_SWAP_CTRL && !swap_complete
        |=> !s_q.swap_finished && swap_target_select == $past(reg_wdata[1:0]))
        else $error("swap control write mishandled");
    a_small_rom_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == ogr_pkg::OFF_ROM
        |=> reg_rdata[7:0] == 8'h00 || reg_rdata[7:0] == 8'h20)
        else $error("small rom offset invalid");
    a_go_starts_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_q.byte_fetch_go && !s_q.rom_pointer_clear && !s_q.boot_pend
        && s_q.st == ogr_pkg::OGR_IDLE |=> ee_req && ee_addr == $past(s_q.ptr))
        else $error("fetch did not start");
    c_fetch_done: cover property (@(posedge clk_sys) disable iff (!rst_n)
        s_q.st == ogr_pkg::OGR_RELEASE ##1 !s_q.byte_fetch_go);
    c_boot_small_rom: cover property (@(posedge clk_sys) disable iff (!rst_n)
        s_q.small_rom && s_q.boot_done);
    c_swap_done: cover property (@(posedge clk_sys) disable iff (!rst_n) swap_complete);
endmodule

//--- core/ogr_retry_if.sv
// Purpose: carrier between the bank and one retry counter
// Assumes: all signals on clk_sys
// Notes: start, bad_ack, retry and give_up are one-cycle pulses
`timescale 1ns/1ps
interface ogr_retry_if #(parameter int W = 4);
    logic [W-1:0] limit;
    logic start;
    logic bad_ack;
    logic retry;
    logic give_up;
    modport unit (input limit, input start, input bad_ack, output retry, output give_up);
    modport ctrl (output limit, output start, output bad_ack, input retry, input give_up);
endinterface

//--- core/ogr_retry_unit.sv
// Purpose: per-packet attempt counter for one transmit unit
// Assumes: bad_ack marks a busy or data-error acknowledge
// Notes: a start in the same cycle as bad_ack wins; that ack is dropped
`timescale 1ns/1ps
module ogr_retry_unit #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // counter link
    ogr_retry_if.unit rif
);
    // elaboration check: the counter width must lie between 1 and 8 bits
    if (W < 1 || W > 8) begin : g_bad_w
        $error("ogr_retry_unit: W out of range");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
        logic retry;
        logic give_up;
    } ogr_rty_st_t;

    ogr_rty_st_t s_q, s_d;

    // retry while under the limit, report the final ack once reached
    always_comb begin
        s_d = s_q;
        s_d.retry = 1'b0;
        s_d.give_up = 1'b0;
        if (rif.start) begin
            s_d.cnt = '0;
        end else if (rif.bad_ack) begin
            if (s_q.cnt < rif.limit) begin
                s_d.retry = 1'b1;
                s_d.cnt = s_q.cnt + 1'b1;
            end else begin
                s_d.give_up = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rif.retry = s_q.retry;
    assign rif.give_up = s_q.give_up;

    a_retry_under_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rif.bad_ack && !rif.start && s_q.cnt < rif.limit |=> rif.retry && !rif.give_up)
        else $error("retry missing below limit");
    a_give_up_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rif.bad_ack && !rif.start && s_q.cnt >= rif.limit |=> rif.give_up && !rif.retry)
        else $error("final ack missing at limit");
    a_start_clears_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rif.start |=> s_q.cnt == '0 && !rif.retry)
        else $error("count not cleared on start");
    c_give_up: cover property (@(posedge clk_sys) disable iff (!rst_n) rif.give_up);
endmodule

//--- test/ogr_ee_model.sv
// Purpose: behavioural serial eeprom on the byte req/ack link
// Assumes: req held until the synced ack has been seen by the bank
// Notes: answers alternate fast and slow; released data is inverted
`timescale 1ns/1ps
module ogr_ee_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // byte link
    input wire logic ee_req,
    input wire logic [7:0] ee_addr,
    output logic ee_ack,
    output logic [7:0] ee_data
);
    logic [3:0] cnt_q;
    logic slow_q;

    // contents: byte n holds n + 31h, so byte 6h has bit 5 set
    function automatic logic [7:0] rom_byte(input logic [7:0] a);
        return a + 8'h31;
    endfunction

    // data settles at least one cycle before ack so the bank never samples it moving
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            slow_q <= 1'b0;
            ee_ack <= 1'b0;
            ee_data <= 8'hFF;
        end else if (ee_req && !ee_ack) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h1) begin
                ee_data <= rom_byte(ee_addr);
            end
            if (cnt_q == (slow_q ? 4'h6 : 4'h2)) begin
                ee_ack <= 1'b1;
            end
        end else if (!ee_req && ee_ack) begin
            // released: show the inverse so a stale byte cannot pass
            ee_ack <= 1'b0;
            ee_data <= ~ee_data;
            slow_q <= ~slow_q;
            cnt_q <= 4'h0;
        end
    end
endmodule

//--- test/test_ogr_regs.sv
// Purpose: self-checking bench of the eeprom, retry and swap register bank
// Assumes: eeprom present until the last reset; inputs change 1 ns after the rising edge
// Notes: reads are checked through one compare task; a hang ends the run
`timescale 1ns/1ps
module test_ogr_regs;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic ee_ack, ee_req, eeprom_present_flag, boot_done;
    logic [7:0] ee_data, ee_addr;
    logic [2:0] unit_start = 3'h0;
    logic [2:0] unit_bad_ack = 3'h0;
    logic [2:0] unit_retry, unit_give_up;
    logic ee_detect = 1'b1;
    logic swap_complete = 1'b0;
    logic swap_value_load = 1'b0;
    logic [31:0] swap_value_in = 32'h0000_0000;
    logic [1:0] swap_target_select;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] v;

    ogr_regs i_ogr_regs (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .ee_detect(ee_detect), .ee_ack(ee_ack), .ee_data(ee_data),
        .ee_req(ee_req), .ee_addr(ee_addr), .eeprom_present_flag(eeprom_present_flag),
        .boot_done(boot_done), .unit_start(unit_start), .unit_bad_ack(unit_bad_ack),
        .unit_retry(unit_retry), .unit_give_up(unit_give_up), .swap_complete(swap_complete),
        .swap_value_load(swap_value_load), .swap_value_in(swap_value_in),
        .swap_target_select(swap_target_select));
    ogr_ee_model i_ogr_ee_model (.clk_sys(clk_sys), .rst_n(rst_n), .ee_req(ee_req),
        .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_data(ee_data));

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            finish_test();
        end
    end

    task automatic finish_test();
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // inputs always move a fixed 1 ns after the edge
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tick();
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick();
        reg_wr = 1'b0;
    endtask

    // data is taken in the cycle that rvalid stands
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        tick();
        reg_rd = 1'b1;
        reg_addr = a;
        tick();
        reg_rd = 1'b0;
        check("read valid", {31'h0, reg_rvalid}, 32'h1);
        d = reg_rdata;
    endtask

    // start a fetch and poll the go bit as the done indication
    task automatic fetch(input logic [7:0] exp);
        logic [31:0] r;
        wr(ogr_pkg::OFF_ROM, 32'h0200_0000);
        for (int i = 0; i < 100; i++) begin
            rd(ogr_pkg::OFF_ROM, r);
            if (r[25] === 1'b0) break;
        end
        check("fetch go", {31'h0, r[25]}, 32'h0);
        check("fetched byte", {24'h0, r[23:16]}, {24'h0, exp});
        check("rom reserved", r & 32'h7D00_FF00, 32'h0);
    endtask

    task automatic unit_pulse(input logic [2:0] st, input logic [2:0] ba);
        tick();
        unit_start = st;
        unit_bad_ack = ba;
        tick();
        unit_start = 3'h0;
        unit_bad_ack = 3'h0;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        // reset values, readable before boot completes
        rd(ogr_pkg::OFF_RETRY, v);
        check("retry reset", v, 32'h0);
        rd(8'h40, v);
        check("unmapped read", v, 32'h0);
        rd(ogr_pkg::OFF_SWAP_CTRL, v);
        check("swap ctrl reset", v, 32'h8000_0000);
        for (int i = 0; i < 200 && boot_done !== 1'b1; i++) tick();
        // eeprom access only once the present flag says so
        check("present flag", {31'h0, eeprom_present_flag}, 32'h1);
        rd(ogr_pkg::OFF_ROM, v);
        check("small rom offset", {24'h0, v[7:0]}, 32'h20);
        check("rom clear idle", {31'h0, v[31]}, 32'h0);
        // fetch twice, clear, then fetched byte must stay at byte 1
        wr(ogr_pkg::OFF_ROM, 32'h8000_0000);
        for (int i = 0; i < 50; i++) begin
            rd(ogr_pkg::OFF_ROM, v);
            if (v[31] === 1'b0) break;
        end
        check("clear done", {31'h0, v[31]}, 32'h0);
        fetch(8'h31);
        fetch(8'h32);
        wr(ogr_pkg::OFF_ROM, 32'h80FF_0000);
        for (int i = 0; i < 50; i++) begin
            rd(ogr_pkg::OFF_ROM, v);
            if (v[31] === 1'b0) break;
        end
        check("clear done", {31'h0, v[31]}, 32'h0);
        check("byte kept", {24'h0, v[23:16]}, 32'h32);
        fetch(8'h31);
        fetch(8'h32);
        // retry limits: read-only bound fields and reserved nibble stay zero
        wr(ogr_pkg::OFF_RETRY, 32'hFFFF_F321);
        rd(ogr_pkg::OFF_RETRY, v);
        check("retry fields", v, 32'h0000_0321);
        // unit u has limit u+1: that many retries, then the final ack
        for (int u = 0; u < 3; u++) begin
            unit_pulse(3'h1 << u, 3'h0);
            for (int k = 0; k <= u + 1; k++) begin
                unit_pulse(3'h0, 3'h1 << u);
                check("unit retry", {29'h0, unit_retry},
                    (k <= u) ? (32'h1 << u) : 32'h0);
                check("unit give up", {29'h0, unit_give_up},
                    (k > u) ? (32'h1 << u) : 32'h0);
            end
        end
        // swap store value is loaded by the engine, not by software
        tick();
        swap_value_load = 1'b1;
        swap_value_in = 32'hDEAD_BEEF;
        tick();
        swap_value_load = 1'b0;
        wr(ogr_pkg::OFF_SWAP_DATA, 32'h1234_5678);
        rd(ogr_pkg::OFF_SWAP_DATA, v);
        check("swap store value", v, 32'hDEAD_BEEF);
        // every target code; a write clears the finished flag
        for (int s = 0; s < 4; s++) begin
            wr(ogr_pkg::OFF_SWAP_CTRL, 32'(s));
            rd(ogr_pkg::OFF_SWAP_CTRL, v);
            check("swap ctrl", v, 32'(s));
            check("target select", {30'h0, swap_target_select}, 32'(s));
        end
        tick();
        swap_complete = 1'b1;
        tick();
        swap_complete = 1'b0;
        rd(ogr_pkg::OFF_SWAP_CTRL, v);
        check("swap finished", v, 32'h8000_0003);
        // mid-run reset with no eeprom: flag low, offset default, retry cleared
        tick();
        rst_n = 1'b0;
        ee_detect = 1'b0;
        tick();
        rst_n = 1'b1;
        for (int i = 0; i < 200 && boot_done !== 1'b1; i++) tick();
        check("boot done absent", {31'h0, boot_done}, 32'h1);
        check("absent flag", {31'h0, eeprom_present_flag}, 32'h0);
        rd(ogr_pkg::OFF_ROM, v);
        check("no small rom", v, 32'h0);
        rd(ogr_pkg::OFF_RETRY, v);
        check("retry after reset", v, 32'h0);
        finish_test();
    end
endmodule
